// ===== rtl/mamr_regs.svh
// What this block does
// - writable addresses and type steer frame matching
// - hash filter low word holds bits 31:0
// - hash filter high word holds bits 63:32
// - low word bit 0 marks multicast address
// - bit 0 compares first received byte lsb
// - high register bits 15:0 hold address 47:32
// - reserved bits 31:16 read back as zero
// - type register holds 16-bit type/length compare
`ifndef MAMR_REGS_SVH
`define MAMR_REGS_SVH

// byte offsets on the register bus
`define MAMR_HASH_LOW_OFS      8'h90
`define MAMR_HASH_HIGH_OFS     8'h94
`define MAMR_ADDR1_LOW_OFS     8'h98
`define MAMR_ADDR1_HIGH_OFS    8'h9C
`define MAMR_ADDR2_LOW_OFS     8'hA0
`define MAMR_ADDR2_HIGH_OFS    8'hA4
`define MAMR_ADDR3_LOW_OFS     8'hA8
`define MAMR_ADDR3_HIGH_OFS    8'hAC
`define MAMR_ADDR4_LOW_OFS     8'hB0
`define MAMR_ADDR4_HIGH_OFS    8'hB4
`define MAMR_TYPE_OFS          8'hB8
`define MAMR_STATUS_OFS        8'hBC

// register indices, offset minus base, divided by four
`define MAMR_HASH_LOW_IDX      4'h0
`define MAMR_HASH_HIGH_IDX     4'h1
`define MAMR_ADDR1_LOW_IDX     4'h2
`define MAMR_ADDR1_HIGH_IDX    4'h3
`define MAMR_ADDR2_LOW_IDX     4'h4
`define MAMR_ADDR2_HIGH_IDX    4'h5
`define MAMR_ADDR3_LOW_IDX     4'h6
`define MAMR_ADDR3_HIGH_IDX    4'h7
`define MAMR_ADDR4_LOW_IDX     4'h8
`define MAMR_ADDR4_HIGH_IDX    4'h9
`define MAMR_TYPE_IDX          4'hA
`define MAMR_STATUS_IDX        4'hB
`define MAMR_NUM_RW            11

// field masks, reset value and bus answers
`define MAMR_HALF_MASK         32'h0000_FFFF
`define MAMR_FULL_MASK         32'hFFFF_FFFF
`define MAMR_RESET_VAL         32'h0000_0000
`define MAMR_ALL_STRB          4'hF
`define MAMR_WORD_ALIGN        2'h0
`define MAMR_RESP_OKAY         2'h0
`define MAMR_RESP_SLVERR       2'h2

`endif

// ===== rtl/mamr_pkg.sv
package mamr_pkg;

   typedef logic [7:0] mamr_addr_t;
   typedef logic [3:0] mamr_idx_t;

   // header fields of a received frame, offered by the receive path
   typedef struct packed {
      logic [47:0] da;         // first received byte in bits 7:0
      logic        da_valid;   // one-cycle strobe
      logic [15:0] len_type;
      logic        type_valid; // one-cycle strobe
   } mamr_rx_hdr_s;

   // result of the comparisons
   typedef struct packed {
      logic [3:0] da_hit;
      logic       da_done;
      logic       type_hit;
      logic       type_done;
   } mamr_match_s;

   // one programmed station address
   typedef struct packed {
      logic [15:0] high;
      logic [31:0] low;
   } mamr_station_s;

endpackage

// ===== rtl/mamr_addr_cmp.sv
module mamr_addr_cmp
   import mamr_pkg::*;
(
   input  wire mamr_station_s i_station,
   input  wire logic [47:0]   i_da,
   output logic               o_hit,
   output logic               o_group_ok
);

   // group bit compared on its own; the top only ANDs it into da_hit, so a kind mismatch shows as a plain miss
   assign o_group_ok = (i_station.low[0] == i_da[0]);
   // exact compare of every bit; a partial match never counts
   assign o_hit = o_group_ok && ({i_station.high, i_station.low} == i_da);

endmodule

// ===== rtl/mamr_top.sv
// Design decision made here: register access over AXI4-Lite.
`include "mamr_regs.svh"

module mamr_top
   import mamr_pkg::*;
(
   input  wire logic         i_sys_clk,
   input  wire logic         i_reset,
   // axi4-lite write address
   input  wire logic         i_awvalid,
   output logic              o_awready,
   input  wire mamr_addr_t   i_awaddr,
   input  wire logic [2:0]   i_awprot,
   // axi4-lite write data
   input  wire logic         i_wvalid,
   output logic              o_wready,
   input  wire logic [31:0]  i_wdata,
   input  wire logic [3:0]   i_wstrb,
   // axi4-lite write response
   output logic              o_bvalid,
   input  wire logic         i_bready,
   output logic [1:0]        o_bresp,
   // axi4-lite read address
   input  wire logic         i_arvalid,
   output logic              o_arready,
   input  wire mamr_addr_t   i_araddr,
   input  wire logic [2:0]   i_arprot,
   // axi4-lite read data
   output logic              o_rvalid,
   input  wire logic         i_rready,
   output logic [31:0]       o_rdata,
   output logic [1:0]        o_rresp,
   // receive path
   input  wire mamr_rx_hdr_s i_rx,
   output mamr_match_s       o_match,
   output logic [3:0]        o_station_group,
   output logic [63:0]       o_hash_filter
);

   // register file and bus state
   logic [31:0]   regs        [0:`MAMR_NUM_RW-1];
   logic [31:0]   next_regs   [0:`MAMR_NUM_RW-1];
   logic          aw_held;
   logic          next_aw_held;
   mamr_addr_t    aw_addr;
   mamr_addr_t    next_aw_addr;
   logic          w_held;
   logic          next_w_held;
   logic [31:0]   w_data;
   logic [31:0]   next_w_data;
   logic [3:0]    w_strb;
   logic [3:0]    next_w_strb;
   logic          next_awready;
   logic          next_wready;
   logic          next_bvalid;
   logic [1:0]    next_bresp;
   logic          next_arready;
   logic          next_rvalid;
   logic [31:0]   next_rdata;
   logic [1:0]    next_rresp;
   mamr_match_s   next_match;
   logic [3:0]    next_station_group;
   logic [3:0]    cmp_hit;
   logic [3:0]    cmp_group_ok;
   logic          wr_fire;
   mamr_idx_t     wr_idx;
   mamr_idx_t     rd_idx;

   // protection bits carry nothing for this block
   logic          prot_unused;
   assign prot_unused = ^{i_awprot, i_arprot};

   // an offset hits when aligned and inside the window
   function automatic logic reg_hit(input mamr_addr_t addr);
      reg_hit = (addr[1:0] == `MAMR_WORD_ALIGN) && (addr >= `MAMR_HASH_LOW_OFS)
                && (addr <= `MAMR_STATUS_OFS);
   endfunction

   // word index relative to the first register
   function automatic mamr_idx_t reg_idx(input mamr_addr_t addr);
      mamr_addr_t diff;
      diff    = addr - `MAMR_HASH_LOW_OFS;
      reg_idx = diff[5:2];
   endfunction

   // halfword registers keep their upper bits at zero
   function automatic logic [31:0] reg_mask(input mamr_idx_t idx);
      if (idx inside {`MAMR_ADDR1_HIGH_IDX, `MAMR_ADDR2_HIGH_IDX, `MAMR_ADDR3_HIGH_IDX,
                      `MAMR_ADDR4_HIGH_IDX, `MAMR_TYPE_IDX}) begin
         reg_mask = `MAMR_HALF_MASK;
      end else begin
         reg_mask = `MAMR_FULL_MASK;
      end
   endfunction

   // byte lanes not strobed keep their old contents
   function automatic logic [31:0] apply_strb(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      apply_strb = res;
   endfunction

   assign wr_fire = aw_held && w_held && !o_bvalid;
   assign wr_idx  = reg_idx(aw_addr);
   assign rd_idx  = reg_idx(i_araddr);

   // address and data are taken in either order; the write lands once both are held
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = o_bvalid;
      next_bresp   = o_bresp;
      for (int r = 0; r < `MAMR_NUM_RW; r++) begin
         next_regs[r] = regs[r];
      end
      if (o_awready && i_awvalid) begin
         next_aw_held = 1'b1;
         next_aw_addr = i_awaddr;
      end
      if (o_wready && i_wvalid) begin
         next_w_held = 1'b1;
         next_w_data = i_wdata;
         next_w_strb = i_wstrb;
      end
      if (o_bvalid && i_bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         if (!reg_hit(aw_addr)) begin
            next_bresp = `MAMR_RESP_SLVERR;
         end else begin
            next_bresp = `MAMR_RESP_OKAY;
            // status is read-only; a write there is accepted and dropped
            if (wr_idx != `MAMR_STATUS_IDX) begin
               next_regs[wr_idx] = apply_strb(regs[wr_idx], w_data, w_strb)
                                   & reg_mask(wr_idx);
            end
         end
      end
      // each channel stays closed while its half waits or a response is pending
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
   end

   // write group registers; everything clears to zero
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         aw_held   <= 1'b0;
         aw_addr   <= '0;
         w_held    <= 1'b0;
         w_data    <= `MAMR_RESET_VAL;
         w_strb    <= '0;
         o_awready <= 1'b0;
         o_wready  <= 1'b0;
         o_bvalid  <= 1'b0;
         o_bresp   <= `MAMR_RESP_OKAY;
         for (int r = 0; r < `MAMR_NUM_RW; r++) begin
            regs[r] <= `MAMR_RESET_VAL;
         end
      end else begin
         aw_held   <= next_aw_held;
         aw_addr   <= next_aw_addr;
         w_held    <= next_w_held;
         w_data    <= next_w_data;
         w_strb    <= next_w_strb;
         o_awready <= next_awready;
         o_wready  <= next_wready;
         o_bvalid  <= next_bvalid;
         o_bresp   <= next_bresp;
         for (int r = 0; r < `MAMR_NUM_RW; r++) begin
            regs[r] <= next_regs[r];
         end
      end
   end

   // one read at a time; arready reopens the cycle after the data is taken
   always_comb begin
      next_rvalid = o_rvalid;
      next_rdata  = o_rdata;
      next_rresp  = o_rresp;
      if (o_rvalid && i_rready) begin
         next_rvalid = 1'b0;
      end
      if (o_arready && i_arvalid) begin
         next_rvalid = 1'b1;
         next_rresp  = `MAMR_RESP_OKAY;
         if (!reg_hit(i_araddr)) begin
            next_rresp = `MAMR_RESP_SLVERR;
            next_rdata = `MAMR_RESET_VAL;
         end else if (rd_idx == `MAMR_STATUS_IDX) begin
            next_rdata = {27'h000_0000, o_match.type_hit, o_match.da_hit};
         end else begin
            next_rdata = regs[rd_idx] & reg_mask(rd_idx);
         end
      end
      next_arready = !next_rvalid;
   end

   // read group registers
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b0;
         o_rdata   <= `MAMR_RESET_VAL;
         o_rresp   <= `MAMR_RESP_OKAY;
      end else begin
         o_arready <= next_arready;
         o_rvalid  <= next_rvalid;
         o_rdata   <= next_rdata;
         o_rresp   <= next_rresp;
      end
   end

   // four station compares, each on its own low/high pair
   for (genvar s = 0; s < 4; s++) begin : g_cmp
      mamr_addr_cmp u_cmp (
         .i_station  ({regs[2*s+3][15:0], regs[2*s+2]}),
         .i_da       (i_rx.da),
         .o_hit      (cmp_hit[s]),
         .o_group_ok (cmp_group_ok[s])
      );
   end

   // results hold until the next strobe of their kind; done flags pulse
   always_comb begin
      next_match           = o_match;
      next_match.da_done   = i_rx.da_valid;
      next_match.type_done = i_rx.type_valid;
      if (i_rx.da_valid) begin
         next_match.da_hit = cmp_hit & cmp_group_ok;
      end
      if (i_rx.type_valid) begin
         next_match.type_hit = (i_rx.len_type == regs[`MAMR_TYPE_IDX][15:0]);
      end
      // group bit of each low word tells unicast from multicast entries
      for (int s = 0; s < 4; s++) begin
         next_station_group[s] = regs[2*s+2][0];
      end
   end

   // match group registers
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_match         <= '0;
         o_station_group <= '0;
      end else begin
         o_match         <= next_match;
         o_station_group <= next_station_group;
      end
   end

   // the hash bits leave as one 64-bit vector for the hash lookup
   assign o_hash_filter = {regs[`MAMR_HASH_HIGH_IDX], regs[`MAMR_HASH_LOW_IDX]};

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   property p_hash_low;
      wr_fire && reg_hit(aw_addr) && wr_idx == `MAMR_HASH_LOW_IDX
         && w_strb == `MAMR_ALL_STRB |=> o_hash_filter[31:0] == $past(w_data);
   endproperty
   a_hash_low: assert property (p_hash_low) else $error("hash low not written");

   property p_hash_high;
      wr_fire && reg_hit(aw_addr) && wr_idx == `MAMR_HASH_HIGH_IDX
         && w_strb == `MAMR_ALL_STRB |=> o_hash_filter[63:32] == $past(w_data);
   endproperty
   a_hash_high: assert property (p_hash_high) else $error("hash high not written");

   property p_group_flag;
      ##1 o_station_group[0] == $past(regs[`MAMR_ADDR1_LOW_IDX][0]);
   endproperty
   a_group_flag: assert property (p_group_flag) else $error("group flag wrong");

   property p_group_cmp;
      i_rx.da_valid && (i_rx.da[0] != regs[`MAMR_ADDR1_LOW_IDX][0])
         |=> !o_match.da_hit[0] && o_match.da_done;
   endproperty
   a_group_cmp: assert property (p_group_cmp) else $error("group bit ignored");

   property p_high_half;
      wr_fire && reg_hit(aw_addr) && wr_idx == `MAMR_ADDR1_HIGH_IDX
         && w_strb == `MAMR_ALL_STRB
         |=> regs[`MAMR_ADDR1_HIGH_IDX] == {16'h0000, $past(w_data[15:0])};
   endproperty
   a_high_half: assert property (p_high_half) else $error("high half wrong");

   property p_rsvd_zero;
      o_arready && i_arvalid && reg_hit(i_araddr)
         && (rd_idx inside {`MAMR_ADDR1_HIGH_IDX, `MAMR_TYPE_IDX})
         |=> o_rvalid && o_rdata[31:16] == 16'h0000;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

   property p_type_cmp;
      i_rx.type_valid |=> o_match.type_done
         && o_match.type_hit == ($past(i_rx.len_type) == $past(regs[`MAMR_TYPE_IDX][15:0]));
   endproperty
   a_type_cmp: assert property (p_type_cmp) else $error("type compare wrong");

   property p_full_match;
      i_rx.da_valid |=> o_match.da_hit[3] == ($past(i_rx.da)
         == $past({regs[`MAMR_ADDR4_HIGH_IDX][15:0], regs[`MAMR_ADDR4_LOW_IDX]}));
   endproperty
   a_full_match: assert property (p_full_match) else $error("address match wrong");

   property p_hold_result;
      !i_rx.da_valid && !i_rx.type_valid |=> $stable(o_match.da_hit)
         && $stable(o_match.type_hit) && !o_match.da_done;
   endproperty
   a_hold_result: assert property (p_hold_result) else $error("result moved");

   property p_write_answer;
      wr_fire |=> o_bvalid ##0 (!o_awready && !o_wready);
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("no write response");

   c_write: cover property (wr_fire && reg_hit(aw_addr));
   c_read_status: cover property (o_arready && i_arvalid && rd_idx == `MAMR_STATUS_IDX);
   c_da_hit: cover property (o_match.da_done && o_match.da_hit[0]);
   c_type_hit: cover property (o_match.type_done && o_match.type_hit);

endmodule

// ===== verif/test_mac_address_match_regs.sv
`include "mamr_regs.svh"

module test_mac_address_match_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import mamr_pkg::*;

   logic         i_sys_clk, i_reset;
   logic         i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   mamr_addr_t   i_awaddr, i_araddr;
   logic [31:0]  i_wdata;
   logic [31:0]  o_rdata;
   logic [1:0]   o_bresp, o_rresp;
   logic         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   mamr_rx_hdr_s i_rx;
   mamr_match_s  o_match;
   logic [3:0]   o_station_group;
   logic [63:0]  o_hash_filter;
   int           bad_count = 0;
   int           cmp_count = 0;

   mamr_top dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
      .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_awprot(3'h0),
      .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(`MAMR_ALL_STRB),
      .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
      .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .i_arprot(3'h0),
      .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
      .i_rx(i_rx), .o_match(o_match), .o_station_group(o_station_group),
      .o_hash_filter(o_hash_filter));

   // 125 MHz system clock
   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end

   // every comparison goes through here so the counts stay honest
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic do_reset();
      @(posedge i_sys_clk);
      i_reset <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      i_reset <= 1'b0;
   endtask

   // aw and w offered together, each dropped at its own handshake edge
   task automatic wr(input mamr_addr_t a, input logic [31:0] d, output logic [1:0] resp);
      int n;
      logic aw_done, w_done;
      @(posedge i_sys_clk);
      i_awaddr  <= a;
      i_wdata   <= d;
      i_awvalid <= 1'b1;
      i_wvalid  <= 1'b1;
      i_bready  <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      n = 0;
      forever begin
         @(posedge i_sys_clk);
         if (o_bvalid === 1'b1 && aw_done && w_done) break;
         if (!aw_done && o_awready === 1'b1) begin
            aw_done = 1'b1;
            i_awvalid <= 1'b0;
         end
         if (!w_done && o_wready === 1'b1) begin
            w_done = 1'b1;
            i_wvalid <= 1'b0;
         end
         n++;
         if (n > 100) begin
            bad_count++;
            end_of_test();
         end
      end
      resp = o_bresp;
      i_bready <= 1'b0;
   endtask

   task automatic rd(input mamr_addr_t a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      logic ar_done;
      @(posedge i_sys_clk);
      i_araddr  <= a;
      i_arvalid <= 1'b1;
      i_rready  <= 1'b1;
      ar_done = 1'b0;
      n = 0;
      forever begin
         @(posedge i_sys_clk);
         if (o_rvalid === 1'b1 && ar_done) break;
         if (!ar_done && o_arready === 1'b1) begin
            ar_done = 1'b1;
            i_arvalid <= 1'b0;
         end
         n++;
         if (n > 100) begin
            bad_count++;
            end_of_test();
         end
      end
      d = o_rdata;
      resp = o_rresp;
      i_rready <= 1'b0;
   endtask

   // one-cycle header strobe; the match shows right after the taking edge
   // the result is kept as the struct so field positions never drift from the package
   task automatic strobe(input logic is_da, input logic [47:0] da, input logic [15:0] lt,
                         output mamr_match_s m);
      @(posedge i_sys_clk);
      i_rx.da         <= da;
      i_rx.len_type   <= lt;
      i_rx.da_valid   <= is_da;
      i_rx.type_valid <= ~is_da;
      @(posedge i_sys_clk);
      i_rx.da_valid   <= 1'b0;
      i_rx.type_valid <= 1'b0;
      #1;
      m = o_match;
   endtask

   // distinct words; bit 0 of the station low words alternates 1,0,1,0
   function automatic logic [31:0] pat(input int i);
      return 32'h9E37_0000 ^ {8'(i), 8'(i), 8'(i), 8'(i >> 1)};
   endfunction

   // halfword registers keep only bits 15:0
   function automatic logic [31:0] kept(input int i);
      if ((i >= 3 && i % 2 == 1) || i == 10) return pat(i) & `MAMR_HALF_MASK;
      return pat(i);
   endfunction

   task automatic check_zero();
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < `MAMR_NUM_RW; i++) begin
         rd(`MAMR_HASH_LOW_OFS + 8'(4 * i), d, r);
         chk(d, 0);
         chk(r, `MAMR_RESP_OKAY);
      end
      chk(o_hash_filter, 0);
   endtask

   initial begin
      repeat (5000) @(posedge i_sys_clk);
      bad_count++;
      end_of_test();
   end

   initial begin
      logic [31:0] d, lo, hi;
      logic [1:0]  r;
      mamr_match_s m;
      logic [47:0] st1;
      i_reset = 1'b1;
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
      i_awaddr = 8'h00;
      i_araddr = 8'h00;
      i_wdata = 32'h0000_0000;
      i_rx = '0;
      do_reset();
      check_zero();
      // program every writable register (status excluded), reserved halves non-zero; pair 1 is our own address
      for (int i = 0; i < `MAMR_NUM_RW; i++) begin
         wr(`MAMR_HASH_LOW_OFS + 8'(4 * i), pat(i), r);
         chk(r, `MAMR_RESP_OKAY);
      end
      for (int i = 0; i < `MAMR_NUM_RW; i++) begin
         rd(`MAMR_HASH_LOW_OFS + 8'(4 * i), d, r);
         chk(d, kept(i));
      end
      chk(o_hash_filter, {pat(1), pat(0)});
      chk(o_station_group, 4'h5);
      // refused accesses leave the registers alone
      wr(8'h92, 32'h0000_0000, r);
      chk(r, `MAMR_RESP_SLVERR);
      rd(8'hC0, d, r);
      chk({r, d}, {`MAMR_RESP_SLVERR, 32'h0000_0000});
      rd(`MAMR_HASH_LOW_OFS, d, r);
      chk(d, pat(0));
      // each station hits only on its own full address
      for (int k = 0; k < 4; k++) begin
         lo = pat(2 * k + 2);
         hi = pat(2 * k + 3);
         strobe(1'b1, {hi[15:0], lo}, 16'h0000, m);
         chk({m.da_hit, m.da_done}, {4'(1 << k), 1'b1});
      end
      lo = pat(2);
      hi = pat(3);
      st1 = {hi[15:0], lo};
      strobe(1'b1, st1 ^ 48'h0000_0000_0001, 16'h0000, m);
      chk({m.da_hit, m.da_done}, 5'h01);
      strobe(1'b1, st1 ^ 48'h8000_0000_0000, 16'h0000, m);
      chk({m.da_hit, m.da_done}, 5'h01);
      // type/length compare, hit then a one-bit miss
      hi = pat(10);
      strobe(1'b0, 48'h0, hi[15:0], m);
      chk({m.type_hit, m.type_done}, 2'h3);
      // status shows the last type hit and the last (missed) address result
      rd(`MAMR_STATUS_OFS, d, r);
      chk({r, d}, {`MAMR_RESP_OKAY, 32'h0000_0010});
      // status is read-only: a write is answered but changes nothing
      wr(`MAMR_STATUS_OFS, 32'hFFFF_FFFF, r);
      chk(r, `MAMR_RESP_OKAY);
      rd(`MAMR_STATUS_OFS, d, r);
      chk(d, 32'h0000_0010);
      strobe(1'b0, 48'h0, hi[15:0] ^ 16'h8000, m);
      chk({m.type_hit, m.type_done}, 2'h1);
      // a second reset in mid-run clears everything again
      do_reset();
      check_zero();
      end_of_test();
   end
endmodule
